// ### src/mon_port.sv
// single-wire monitor command port: security entry, echo, write, indexed read, run
// assumes SER_LINE is the resolved wired-OR level, synchronous to CLK
// assumes memory answers a read in the same cycle that re is high, with MEM_PROT for that address
`timescale 1ns/1ps
`default_nettype none
module mon_port #(
    parameter int BIT_DIV = mon_pkg::BIT_DIV_FAST,
    parameter int DIV_W = 12
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic POR,
    input wire logic DIV_SEL,
    input wire logic SER_LINE,
    output logic SER_DRV,
    output logic SER_EN,
    output mon_pkg::mem_req_t MEM,
    input wire logic [7:0] MEM_DATA,
    input wire logic MEM_PROT,
    input wire logic EXEC_ROM,
    output logic RUN_RTI,
    output logic ILL_RST,
    output logic BYPASS
);
    if (BIT_DIV < 4 || 2 * BIT_DIV >= (1 << DIV_W)) begin : g_div_check
        $error("mon_port: bad BIT_DIV");
    end

    // ------------------------------------------------------------
    // bit timing
    // ------------------------------------------------------------
    logic [DIV_W-1:0] period;
    logic rx_tick, tx_tick, rx_start;
    logic rx_busy_r, rx_wait_hi_r, rx_done_r, rx_brk_r;
    logic [3:0] rx_n_r;
    logic [8:0] rx_sh_r;
    logic [7:0] rx_byte_r;
    logic tx_busy_r, tx_load;
    logic [11:0] tx_sh_r, tx_frame;
    logic [3:0] tx_n_r, tx_len;
    mon_pkg::state_t state_r;

    // select low bypasses the divide-by-two: twice the rate
    assign period = DIV_SEL ? DIV_W'(2 * BIT_DIV) : DIV_W'(BIT_DIV);

    baud_tick #(.W(DIV_W)) u_rx_tick (
        .clk(CLK), .rst(RST), .run(rx_busy_r), .restart(rx_start), .half(1'b1),
        .period(period), .tick(rx_tick)
    );
    baud_tick #(.W(DIV_W)) u_tx_tick (
        .clk(CLK), .rst(RST), .run(tx_busy_r), .restart(tx_load), .half(1'b0),
        .period(period), .tick(tx_tick)
    );

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    // deaf while sending: on the single wire we would hear our own echo
    assign rx_start = !rx_busy_r && !rx_wait_hi_r && !tx_busy_r && !SER_LINE
                      && state_r != mon_pkg::S_USER;

    always_ff @(posedge CLK) begin
        if (RST) begin
            rx_busy_r <= 1'b0;
            rx_wait_hi_r <= 1'b0;
            rx_done_r <= 1'b0;
            rx_brk_r <= 1'b0;
            rx_n_r <= 4'h0;
            rx_sh_r <= 9'h000;
            rx_byte_r <= 8'h00;
        end else begin
            rx_done_r <= 1'b0;
            if (rx_wait_hi_r && SER_LINE) rx_wait_hi_r <= 1'b0;
            if (rx_start) begin
                rx_busy_r <= 1'b1;
                rx_n_r <= 4'h0;
            end else if (rx_busy_r && rx_tick) begin
                if (rx_n_r == 4'h0 && SER_LINE) begin
                    rx_busy_r <= 1'b0;
                end else begin
                    rx_sh_r <= {SER_LINE, rx_sh_r[8:1]};
                    rx_n_r <= rx_n_r + 4'h1;
                    if (rx_n_r == mon_pkg::STOP_POS) begin
                        rx_busy_r <= 1'b0;
                        rx_done_r <= 1'b1;
                        rx_byte_r <= rx_sh_r[8:1];
                        // low stop with all-zero data is a break
                        rx_brk_r <= !SER_LINE && rx_sh_r[8:1] == 8'h00;
                        rx_wait_hi_r <= !SER_LINE;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // transmit source selection
    // ------------------------------------------------------------
    logic brk_go, res_go;
    logic [7:0] res_byte;

    assign brk_go = state_r == mon_pkg::S_BRK && !tx_busy_r && !rx_done_r;
    assign res_go = state_r == mon_pkg::S_RES && !tx_busy_r && !rx_done_r;
    assign res_byte = (MEM_PROT && !BYPASS) ? mon_pkg::PROT_FILL : MEM_DATA;

    always_comb begin
        tx_load = 1'b0;
        tx_frame = 12'hFFF;
        tx_len = mon_pkg::FRAME_BITS;
        if (rx_done_r && state_r != mon_pkg::S_USER) begin
            tx_load = 1'b1;
            if (rx_brk_r) begin
                tx_frame = 12'h003;
                tx_len = mon_pkg::BRK_ECHO_BITS;
            end else begin
                tx_frame = {3'b111, rx_byte_r, 1'b0};
            end
        end else if (brk_go) begin
            tx_load = 1'b1;
            tx_frame = 12'h000;
        end else if (state_r == mon_pkg::S_RESW) begin
            tx_load = 1'b1;
            tx_frame = {3'b111, res_byte, 1'b0};
        end
    end

    // ------------------------------------------------------------
    // transmitter: open drain, enable means pulling the pin low
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            tx_busy_r <= 1'b0;
            tx_sh_r <= 12'hFFF;
            tx_n_r <= 4'h0;
            SER_EN <= 1'b0;
            SER_DRV <= 1'b0;
        end else begin
            SER_DRV <= 1'b0;
            if (tx_load) begin
                tx_busy_r <= 1'b1;
                tx_sh_r <= tx_frame;
                tx_n_r <= tx_len;
                SER_EN <= !tx_frame[0];
            end else if (tx_busy_r && tx_tick) begin
                tx_sh_r <= {1'b1, tx_sh_r[11:1]};
                tx_n_r <= tx_n_r - 4'h1;
                if (tx_n_r == 4'h1) begin
                    tx_busy_r <= 1'b0;
                    SER_EN <= 1'b0;
                end else begin
                    SER_EN <= !tx_sh_r[1];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    logic [7:0] sec_buf [8];
    logic [2:0] idx_r;
    logic match_r, chk_end, match_fin;
    logic [15:0] ptr_r;
    logic [7:0] ah_r, al_r;
    logic [1:0] res_n_r;
    logic byte_in;

    assign byte_in = rx_done_r && !rx_brk_r;
    assign chk_end = state_r == mon_pkg::S_CHKW && idx_r == mon_pkg::SEC_LAST;
    assign match_fin = match_r && MEM_DATA == sec_buf[idx_r];

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_r <= mon_pkg::S_SEC;
            idx_r <= 3'h0;
            match_r <= 1'b1;
            ptr_r <= 16'h0000;
            ah_r <= 8'h00;
            al_r <= 8'h00;
            res_n_r <= 2'h0;
            MEM <= '0;
            RUN_RTI <= 1'b0;
        end else begin
            MEM.re <= 1'b0;
            MEM.we <= 1'b0;
            RUN_RTI <= 1'b0;
            case (state_r)
                mon_pkg::S_SEC: begin
                    if (byte_in) begin
                        sec_buf[idx_r] <= rx_byte_r;
                        idx_r <= idx_r + 3'h1;
                        if (idx_r == mon_pkg::SEC_LAST) state_r <= mon_pkg::S_CHK;
                    end
                end
                mon_pkg::S_CHK: begin
                    MEM.re <= 1'b1;
                    MEM.addr <= mon_pkg::SEC_BASE + {13'h0000, idx_r};
                    state_r <= mon_pkg::S_CHKW;
                end
                mon_pkg::S_CHKW: begin
                    match_r <= match_fin;
                    idx_r <= idx_r + 3'h1;
                    state_r <= chk_end ? mon_pkg::S_BRK : mon_pkg::S_CHK;
                end
                mon_pkg::S_BRK: begin
                    if (brk_go) state_r <= mon_pkg::S_CMD;
                end
                mon_pkg::S_CMD: begin
                    if (byte_in) begin
                        if (rx_byte_r == mon_pkg::OP_WRITE) begin
                            state_r <= mon_pkg::S_AH;
                        end else if (rx_byte_r == mon_pkg::OP_INDEXED_READ_COMMAND) begin
                            res_n_r <= mon_pkg::RESULT_BYTES;
                            state_r <= mon_pkg::S_RES;
                        end else if (rx_byte_r == mon_pkg::OP_RUN) begin
                            RUN_RTI <= 1'b1;
                            state_r <= mon_pkg::S_USER;
                        end
                    end
                end
                mon_pkg::S_AH, mon_pkg::S_AL, mon_pkg::S_DAT: begin
                    // a break in the middle abandons the partial command
                    if (rx_done_r && rx_brk_r) begin
                        state_r <= mon_pkg::S_CMD;
                    end else if (byte_in && state_r == mon_pkg::S_AH) begin
                        ah_r <= rx_byte_r;
                        state_r <= mon_pkg::S_AL;
                    end else if (byte_in && state_r == mon_pkg::S_AL) begin
                        al_r <= rx_byte_r;
                        state_r <= mon_pkg::S_DAT;
                    end else if (byte_in) begin
                        MEM.we <= 1'b1;
                        MEM.addr <= {ah_r, al_r};
                        MEM.wdata <= rx_byte_r;
                        ptr_r <= {ah_r, al_r};
                        state_r <= mon_pkg::S_CMD;
                    end
                end
                mon_pkg::S_RES: begin
                    if (res_go) begin
                        MEM.re <= 1'b1;
                        MEM.addr <= ptr_r + 16'h0001;
                        ptr_r <= ptr_r + 16'h0001;
                        state_r <= mon_pkg::S_RESW;
                    end
                end
                mon_pkg::S_RESW: begin
                    res_n_r <= res_n_r - 2'h1;
                    state_r <= (res_n_r == 2'h1) ? mon_pkg::S_CMD : mon_pkg::S_RES;
                end
                default: begin
                    state_r <= mon_pkg::S_USER;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // security state: survives every reset except power-on
    // ------------------------------------------------------------
    logic boot_por_r, fail_r;

    always_ff @(posedge CLK) begin
        if (RST) begin
            boot_por_r <= POR;
            if (POR) begin
                BYPASS <= 1'b0;
                fail_r <= 1'b0;
            end
        end else if (chk_end && boot_por_r) begin
            BYPASS <= match_fin;
            fail_r <= !match_fin;
        end
        // non-power-on entry: bytes are taken but the verdict is kept
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ILL_RST <= 1'b0;
        end else begin
            ILL_RST <= (fail_r && !boot_por_r) || (EXEC_ROM && !BYPASS);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_write;
        @(posedge CLK) disable iff (RST)
        (state_r == mon_pkg::S_DAT && byte_in) |=> MEM.we && MEM.addr == {ah_r, al_r}
            && MEM.wdata == $past(rx_byte_r);
    endproperty
    a_write: assert property (p_write) else $error("write not issued");

    property p_indexed_read_command_step;
        @(posedge CLK) disable iff (RST)
        res_go |=> MEM.re && ptr_r == $past(ptr_r) + 16'h0001 ##1 tx_busy_r;
    endproperty
    a_indexed_read_command_step: assert property (p_indexed_read_command_step) else $error("indexed read step");

    property p_run;
        @(posedge CLK) disable iff (RST)
        (state_r == mon_pkg::S_CMD && byte_in && rx_byte_r == mon_pkg::OP_RUN)
            |=> RUN_RTI ##1 !RUN_RTI && state_r == mon_pkg::S_USER;
    endproperty
    a_run: assert property (p_run) else $error("run not taken");

    property p_brk_late;
        @(posedge CLK) disable iff (RST)
        (tx_load && tx_frame == 12'h000) |-> state_r == mon_pkg::S_BRK && idx_r == 3'h0;
    endproperty
    a_brk_late: assert property (p_brk_late) else $error("early ready break");

    property p_echo;
        @(posedge CLK) disable iff (RST)
        (rx_done_r && state_r != mon_pkg::S_USER) |=> tx_busy_r && !rx_busy_r;
    endproperty
    a_echo: assert property (p_echo) else $error("byte not echoed");

    property p_brk_gap;
        @(posedge CLK) disable iff (RST)
        (rx_done_r && rx_brk_r) |=> !SER_EN [*2] ##0 tx_n_r == mon_pkg::BRK_ECHO_BITS;
    endproperty
    a_brk_gap: assert property (p_brk_gap) else $error("break echo gap");

    property p_mask;
        @(posedge CLK) disable iff (RST)
        (state_r == mon_pkg::S_RESW && MEM_PROT && !BYPASS)
            |=> tx_sh_r[8:1] == mon_pkg::PROT_FILL;
    endproperty
    a_mask: assert property (p_mask) else $error("protected data leaked");

    property p_loop;
        @(posedge CLK) disable iff (RST)
        (fail_r && !boot_por_r) |=> ILL_RST;
    endproperty
    a_loop: assert property (p_loop) else $error("no illegal reset loop");

    property p_keep;
        @(posedge CLK) disable iff (RST)
        (chk_end && !boot_por_r) |=> $stable(BYPASS);
    endproperty
    a_keep: assert property (p_keep) else $error("bypass changed");
endmodule : mon_port
`default_nettype wire

// ### include/mon_pkg.sv
// constants, types and carriers shared by the monitor command port
// assumes the system clock stands in for the crystal clock
package mon_pkg;

    localparam logic [7:0] OP_WRITE = 8'h49;
    localparam logic [7:0] OP_INDEXED_READ_COMMAND = 8'h1A;
    localparam logic [7:0] OP_RUN = 8'h28;
    localparam logic [15:0] SEC_BASE = 16'hFFF6;
    localparam logic [2:0] SEC_LAST = 3'h7;
    localparam logic [7:0] PROT_FILL = 8'h00;
    localparam logic [1:0] RESULT_BYTES = 2'h2;

    // bit time as a fixed division of the crystal clock
    localparam longint XTAL_REF_HZ = 64'd4915200;
    localparam longint BAUD_FAST_MILLI = 64'd8904350;
    localparam int BIT_DIV_FAST =
        int'((XTAL_REF_HZ * 1000 + BAUD_FAST_MILLI / 2) / BAUD_FAST_MILLI);
    localparam int MAX_BAUD = 28800;

    localparam logic [3:0] FRAME_BITS = 4'hA;
    localparam logic [3:0] BRK_ECHO_BITS = 4'hC;
    localparam logic [3:0] STOP_POS = 4'h9;

    typedef enum logic [3:0] {
        S_SEC = 4'b0000,
        S_CHK = 4'b0001,
        S_CHKW = 4'b0010,
        S_BRK = 4'b0011,
        S_CMD = 4'b0100,
        S_AH = 4'b0101,
        S_AL = 4'b0110,
        S_DAT = 4'b0111,
        S_RES = 4'b1000,
        S_RESW = 4'b1001,
        S_USER = 4'b1010
    } state_t;

    typedef struct packed {
        logic re;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

endpackage : mon_pkg

// ### src/baud_tick.sv
// bit-time enable generator for one direction of the serial pin
// assumes one clock; restart realigns the count, half gives a mid-bit first tick
`timescale 1ns/1ps
`default_nettype none
module baud_tick #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic restart,
    input wire logic half,
    input wire logic [W-1:0] period,
    output logic tick
);
    logic [W-1:0] cnt_r;

    if (W < 3) begin : g_w_check
        $error("baud_tick: counter too narrow");
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (restart) begin
            cnt_r <= half ? (period >> 1) - W'(1) : period - W'(1);
        end else if (run) begin
            cnt_r <= (cnt_r == '0) ? period - W'(1) : cnt_r - W'(1);
        end
    end

    assign tick = run && !restart && (cnt_r == '0);
endmodule : baud_tick
`default_nettype wire

// ### dv/host_link.sv
// host computer model on the single-wire monitor pin
// assumes the pin is wired-OR with a pull-up and the device pulls it low through en
`timescale 1ns/1ps
`default_nettype none
module host_link (
    input wire logic clk,
    input wire logic en,
    input wire logic [4:0] per,
    output logic line_out
);
    int rxq[$];

    initial line_out = 1'b1;

    // ----------------------------------------
    // transmit
    // ----------------------------------------
    // bit 0 first; every bit lasts one full bit time
    task automatic send(input logic [9:0] frame);
        for (int i = 0; i < 10; i++) begin
            line_out <= frame[i];
            repeat (per) @(posedge clk);
        end
    endtask : send

    task automatic send_byte(input logic [7:0] b);
        send({1'b1, b, 1'b0});
    endtask : send_byte

    // start plus nine lows, then let the pull-up take the line
    task automatic send_break();
        send(10'h000);
        line_out <= 1'b1;
        @(posedge clk);
    endtask : send_break

    // ----------------------------------------
    // receive
    // ----------------------------------------
    // breaks are queued as 256 so they never alias a data byte
    always begin : rx
        logic [9:0] f;
        @(posedge clk iff en);
        repeat (per / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            f[i] = ~en;
            if (i < 9) repeat (per) @(posedge clk);
        end
        if (f == 10'h000) begin
            while (en) @(posedge clk);
            rxq.push_back(256);
        end else begin
            rxq.push_back(int'(f[8:1]));
        end
    end
endmodule : host_link
`default_nettype wire

// ### dv/tb_mon_port.sv
// self-checking bench for the monitor command port
// assumes host_link on the pin and a flat 64K memory with the upper half protected
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_mon_port;
    localparam int DIV = 8;
    logic clk = 1'b0, rst = 1'b1, por = 1'b1, div_sel = 1'b0, exec_rom = 1'b0;
    logic ser_drv, ser_en, run_rti, ill_rst, bypass, host_out, byp_m;
    mon_pkg::mem_req_t mem_req;
    logic [7:0] mem [0:65535];
    logic [15:0] ptr;
    int err_total = 0, total_checks = 0, seed = 19565, rti_cnt = 0;
    int expq[$];
    wire logic ser_line = host_out & ~(ser_en & ~ser_drv);
    wire logic [4:0] per = div_sel ? 5'(2 * DIV) : 5'(DIV);
    wire logic [7:0] mem_data = mem[mem_req.addr];
    wire logic mem_prot = mem_req.addr[15];

    always #10 clk = ~clk;

    mon_port #(.BIT_DIV(DIV)) mon_port_inst (.CLK(clk), .RST(rst), .POR(por),
        .DIV_SEL(div_sel), .SER_LINE(ser_line), .SER_DRV(ser_drv), .SER_EN(ser_en),
        .MEM(mem_req), .MEM_DATA(mem_data), .MEM_PROT(mem_prot), .EXEC_ROM(exec_rom),
        .RUN_RTI(run_rti), .ILL_RST(ill_rst), .BYPASS(bypass));
    host_link host_link_inst (.clk(clk), .en(ser_en), .per(per), .line_out(host_out));

    always @(posedge clk) begin
        if (mem_req.we === 1'b1) mem[mem_req.addr] <= mem_req.wdata;
        if (run_rti === 1'b1) rti_cnt <= rti_cnt + 1;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict

    // wait for every expected frame, then make sure no extra one follows
    task automatic settle();
        int n = 0;
        int e_v, g_v;
        while (host_link_inst.rxq.size() < expq.size() && n < 3000) begin
            @(posedge clk);
            n++;
        end
        repeat (4 * per) @(posedge clk);
        `CHK("frames", expq.size(), host_link_inst.rxq.size())
        // pop once: the macro evaluates its arguments twice on a mismatch
        while (expq.size() > 0 && host_link_inst.rxq.size() > 0) begin
            e_v = expq.pop_front();
            g_v = host_link_inst.rxq.pop_front();
            `CHK("frame", e_v, g_v)
        end
        expq.delete();
        host_link_inst.rxq.delete();
    endtask : settle

    task automatic xb(input logic [7:0] b);
        host_link_inst.send_byte(b);
        expq.push_back(int'(b));
        settle();
    endtask : xb

    task automatic do_reset(input logic p, input logic ds);
        rst <= 1'b1;
        por <= p;
        div_sel <= ds;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    // security entry; the ready break only after the eighth byte
    task automatic entry(input bit good);
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            b = mem[16'(16'hFFF6 + i)] ^ (good ? 8'h00 : 8'h5A);
            host_link_inst.send_byte(b);
            expq.push_back(int'(b));
            if (i == 7) expq.push_back(256);
            settle();
        end
    endtask : entry

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] s [4];
        s = '{mon_pkg::OP_WRITE, a[15:8], a[7:0], d};
        foreach (s[i]) xb(s[i]);
        `CHK("stored byte", d, mem[a])
        ptr = a;
    endtask : wr

    task automatic indexed_read_command();
        host_link_inst.send_byte(mon_pkg::OP_INDEXED_READ_COMMAND);
        expq.push_back(int'(mon_pkg::OP_INDEXED_READ_COMMAND));
        repeat (2) begin
            ptr = ptr + 16'h0001;
            expq.push_back((ptr[15] && !byp_m) ? int'(mon_pkg::PROT_FILL) : int'(mem[ptr]));
        end
        settle();
    endtask : indexed_read_command

    // rom execution attempt: the reset request is a one-cycle pulse
    task automatic rom_exec(input logic exp);
        exec_rom <= 1'b1;
        @(posedge clk);
        exec_rom <= 1'b0;
        @(posedge clk);
        `CHK("illegal reset on rom run", exp, ill_rst)
        @(posedge clk);
        `CHK("illegal reset released", 1'b0, ill_rst)
    endtask : rom_exec

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'($random(seed));
        do_reset(1'b1, 1'b0);
        entry(1'b1);
        `CHK("bypass after match", 1'b1, bypass)
        byp_m = 1'b1;
        $display("test secure entry done");
        wr(16'($random(seed)) & 16'h7FFF, 8'($random(seed)));
        indexed_read_command();
        indexed_read_command();
        wr(16'hFFFE, 8'($random(seed)));
        indexed_read_command();
        $display("test write and indexed read done");
        xb(mon_pkg::OP_WRITE);
        host_link_inst.send_break();
        expq.push_back(256);
        settle();
        wr(16'($random(seed)) & 16'h7FFF, 8'($random(seed)));
        $display("test break echo done");
        do_reset(1'b0, 1'b1);
        entry(1'b0);
        `CHK("bypass kept", 1'b1, bypass)
        rom_exec(1'b0);
        wr(16'h8000 | 16'($random(seed)), 8'($random(seed)));
        indexed_read_command();
        xb(mon_pkg::OP_RUN);
        `CHK("run pulses", 1, rti_cnt)
        $display("test warm reset and run done");
        do_reset(1'b1, 1'b0);
        entry(1'b0);
        byp_m = 1'b0;
        `CHK("bypass after mismatch", 1'b0, bypass)
        `CHK("no illegal reset yet", 1'b0, ill_rst)
        wr(16'hFFF0, 8'($random(seed)));
        indexed_read_command();
        rom_exec(1'b1);
        $display("test failed security done");
        do_reset(1'b0, 1'b0);
        // the request is launched at the first edge after release
        @(posedge clk);
        `CHK("illegal reset loop", 1'b1, ill_rst)
        repeat (50) @(posedge clk);
        `CHK("illegal reset held", 1'b1, ill_rst)
        $display("test reset loop done");
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule : tb_mon_port
`default_nettype wire
